// ---- e3_alarm_defines.svh ----
// register map, field positions, reset values and timing constants
// assumes an 8-bit register port and a 125 MHz system clock
`ifndef E3_ALARM_DEFINES_SVH
`define E3_ALARM_DEFINES_SVH

// =====================================================
// register addresses
`define E3A_ADDR_CFG_STAT2 8'h11
`define E3A_ADDR_IRQ_EN1 8'h12
`define E3A_ADDR_IRQ_STAT1 8'h14

// =====================================================
// field positions
`define E3A_BIT_TIMING_SEL 7
`define E3A_BIT_LOSS_STATE 6
`define E3A_BIT_OOF_STATE 5
`define E3A_BIT_ALARM_STATE 3
`define E3A_BIT_ALARM_IRQ 0
`define E3A_BIT_LOSS_IRQ 2
`define E3A_BIT_ALIGN_IRQ 4
`define E3A_IRQ_EN_WIDTH 5

// =====================================================
// reset values
`define E3A_RST_IRQ_EN1 5'h00
`define E3A_RST_IRQ_STAT1 5'h00
`define E3A_RST_TIMING_SEL 1'b0

// =====================================================
// detection thresholds
`define E3A_OOF_ERR_FRAMES 3'h4
`define E3A_ALARM_MAX_ZEROS 4'h7
`define E3A_ALARM_RUN_FRAMES 2'h2

// =====================================================
// timing
`define E3A_CLK_PERIOD_NS 8
`define E3A_LOSS_SHORT_MS 1
`define E3A_LOSS_LONG_MS 3
`define E3A_NS_PER_MS 1000000
`define E3A_LOSS_SHORT_CYC ((`E3A_LOSS_SHORT_MS * `E3A_NS_PER_MS) / `E3A_CLK_PERIOD_NS)
`define E3A_LOSS_LONG_CYC ((`E3A_LOSS_LONG_MS * `E3A_NS_PER_MS) / `E3A_CLK_PERIOD_NS)
`define E3A_LOSS_TMR_W 19

`endif

// ---- e3_alarm_pkg.sv ----
// types shared by the receive alarm interrupt block
// assumes nothing of its surroundings
`default_nettype none

package e3_alarm_pkg;

   // =====================================================
   // framer synchronisation states
   typedef enum logic [1:0] {
      SYNC_IN_FRAME,
      SYNC_OUT_OF_FRAME,
      SYNC_FRAME_LOST
   } sync_state_e;

endpackage

`default_nettype wire

// ---- e3_frame_sync_monitor.sv ----
// out-of-frame and frame-loss tracking with held payload alignment
// assumes one frame_end pulse per received frame with fas_error valid alongside
`default_nettype none
`include "e3_alarm_defines.svh"

module e3_frame_sync_monitor
   import e3_alarm_pkg::*;
#(
   parameter int ALIGN_W = 11,
   parameter int LOSS_SHORT_CYC = `E3A_LOSS_SHORT_CYC,
   parameter int LOSS_LONG_CYC = `E3A_LOSS_LONG_CYC
)(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic frame_end,
   input wire logic fas_error,
   input wire logic sync_found,
   input wire logic [ALIGN_W-1:0] sync_align,
   input wire logic timing_sel,
   output logic out_of_frame_state,
   output logic frame_loss_state,
   output logic [ALIGN_W-1:0] payload_align,
   output logic frame_alignment_change
);

   sync_state_e state_r, state_nxt;
   logic [2:0] err_cnt_r, err_cnt_nxt;
   logic [`E3A_LOSS_TMR_W-1:0] tmr_r, tmr_nxt, tmr_lim;
   logic [ALIGN_W-1:0] align_r, align_nxt;
   logic change_r, change_nxt;

   // =====================================================
   // next state
   always_comb
   begin
      state_nxt = state_r;
      err_cnt_nxt = err_cnt_r;
      tmr_nxt = tmr_r;
      align_nxt = align_r;
      change_nxt = 1'b0;
      tmr_lim = timing_sel ? `E3A_LOSS_TMR_W'(LOSS_LONG_CYC - 1) : `E3A_LOSS_TMR_W'(LOSS_SHORT_CYC - 1);
      case (state_r)
         SYNC_IN_FRAME:
         begin
            if (frame_end)
            begin
               if (!fas_error)
                  err_cnt_nxt = 3'h0;
               else if (err_cnt_r + 3'h1 >= `E3A_OOF_ERR_FRAMES)
               begin
                  state_nxt = SYNC_OUT_OF_FRAME;
                  err_cnt_nxt = 3'h0;
                  tmr_nxt = '0;
               end
               else
                  err_cnt_nxt = err_cnt_r + 3'h1;
            end
         end
         SYNC_OUT_OF_FRAME, SYNC_FRAME_LOST:
         begin
            if (sync_found)
            begin
               state_nxt = SYNC_IN_FRAME;
               align_nxt = sync_align;
               change_nxt = (sync_align != align_r);
            end
            else if (state_r == SYNC_OUT_OF_FRAME)
            begin
               if (tmr_r >= tmr_lim)
                  state_nxt = SYNC_FRAME_LOST;
               else
                  tmr_nxt = tmr_r + `E3A_LOSS_TMR_W'(1);
            end
         end
         default:
            state_nxt = SYNC_IN_FRAME;
      endcase
   end

   // =====================================================
   // registers
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_r <= SYNC_IN_FRAME;
         err_cnt_r <= 3'h0;
         tmr_r <= '0;
         align_r <= '0;
         change_r <= 1'b0;
      end
      else if (clk_en)
      begin
         state_r <= state_nxt;
         err_cnt_r <= err_cnt_nxt;
         tmr_r <= tmr_nxt;
         align_r <= align_nxt;
         change_r <= change_nxt;
      end
   end

   assign out_of_frame_state = (state_r != SYNC_IN_FRAME);
   assign frame_loss_state = (state_r == SYNC_FRAME_LOST);
   assign payload_align = align_r;
   assign frame_alignment_change = change_r;

endmodule

`default_nettype wire

// ---- e3_alarm_detector.sv ----
// alarm indication detection from zero density per received frame
// assumes bit_valid marks each received bit and frame_end the last bit of a frame
`default_nettype none
`include "e3_alarm_defines.svh"

module e3_alarm_detector
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic bit_valid,
   input wire logic bit_data,
   input wire logic frame_end,
   output logic alarm_indication_state
);

   logic [3:0] zeros_r, zeros_nxt, zeros_now;
   logic [1:0] run_r, run_nxt;
   logic state_r, state_nxt;
   logic low_frame;

   // =====================================================
   // next state
   always_comb
   begin
      zeros_nxt = zeros_r;
      run_nxt = run_r;
      state_nxt = state_r;
      zeros_now = zeros_r;
      // count saturates at 8, enough to separate the two cases
      if (bit_valid && !bit_data && zeros_r != 4'h8)
         zeros_now = zeros_r + 4'h1;
      low_frame = (zeros_now <= `E3A_ALARM_MAX_ZEROS);
      if (frame_end)
      begin
         zeros_nxt = 4'h0;
         // run counts frames that disagree with the present state
         if (low_frame != state_r)
         begin
            if (run_r + 2'h1 >= `E3A_ALARM_RUN_FRAMES)
            begin
               state_nxt = low_frame;
               run_nxt = 2'h0;
            end
            else
               run_nxt = run_r + 2'h1;
         end
         else
            run_nxt = 2'h0;
      end
      else
         zeros_nxt = zeros_now;
   end

   // =====================================================
   // registers
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         zeros_r <= 4'h0;
         run_r <= 2'h0;
         state_r <= 1'b0;
      end
      else if (clk_en)
      begin
         zeros_r <= zeros_nxt;
         run_r <= run_nxt;
         state_r <= state_nxt;
      end
   end

   assign alarm_indication_state = state_r;

endmodule

`default_nettype wire

// ---- e3_rx_alarm_interrupts.sv ----
// receive E3 alarm interrupt block: defect detection, enables, read-clear status, irq
// assumes synchronous register strobes and framer inputs on sys_clk
//
// Behaviour
// - an enable bit of 1 lets its source interrupt, 0 blocks it
// - an enabled alarm interrupt drives the request output low
// - frame-loss change interrupt gated by enable bit 2
// - frame-loss change sets status bit 2
// - frame-loss change raised on both declaration and clearing
// - frame loss declared if out-of-frame lasts past the 1ms or 3ms window
// - alarm indication change raised on both declaration and clearing
// - alarm declared after two consecutive frames with seven or fewer zeros
// - alarm cleared after two consecutive frames with eight or more zeros
// - alarm indication change interrupt gated by enable bit 0
// - alarm indication change sets status bit 0
// - live alarm state readable at bit 3 of config and status two
// - alignment change interrupt raised on abrupt alignment change when enabled
// - out-of-frame declared after four consecutive frames with framing errors
// - previous alignment kept for payload extraction while out of frame
// - alignment change event only when resync needed a different alignment
// - alignment change interrupt gated by enable bit 4
// - alignment change sets status bit 4
`default_nettype none
`include "e3_alarm_defines.svh"

module e3_rx_alarm_interrupts
   import e3_alarm_pkg::*;
#(
   parameter int ALIGN_W = 11,
   parameter int LOSS_SHORT_CYC = `E3A_LOSS_SHORT_CYC,
   parameter int LOSS_LONG_CYC = `E3A_LOSS_LONG_CYC
)(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic rx_bit_valid,
   input wire logic rx_bit,
   input wire logic rx_frame_end,
   input wire logic rx_fas_error,
   input wire logic rx_sync_found,
   input wire logic [ALIGN_W-1:0] rx_sync_align,
   output logic [ALIGN_W-1:0] payload_align,
   output logic out_of_frame_state,
   output logic frame_loss_state,
   output logic alarm_indication_state,
   output logic irq_n
);

   logic frame_alignment_change;
   logic timing_sel_r, timing_sel_nxt;
   logic [`E3A_IRQ_EN_WIDTH-1:0] irq_en_r, irq_en_nxt;
   logic [`E3A_IRQ_EN_WIDTH-1:0] irq_stat_r, irq_stat_nxt;
   logic [`E3A_IRQ_EN_WIDTH-1:0] events;
   logic loss_prev_r, alarm_prev_r;
   logic [7:0] rdata_r, rdata_nxt;
   logic clear_on_read;

   // =====================================================
   // address decode
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
      hit = (addr == target);
   endfunction

   // =====================================================
   // defect detectors
   e3_frame_sync_monitor #(
      .ALIGN_W(ALIGN_W),
      .LOSS_SHORT_CYC(LOSS_SHORT_CYC),
      .LOSS_LONG_CYC(LOSS_LONG_CYC)
   ) u_sync (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .frame_end(rx_frame_end),
      .fas_error(rx_fas_error),
      .sync_found(rx_sync_found),
      .sync_align(rx_sync_align),
      .timing_sel(timing_sel_r),
      .out_of_frame_state(out_of_frame_state),
      .frame_loss_state(frame_loss_state),
      .payload_align(payload_align),
      .frame_alignment_change(frame_alignment_change)
   );

   e3_alarm_detector u_alarm (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .bit_valid(rx_bit_valid),
      .bit_data(rx_bit),
      .frame_end(rx_frame_end),
      .alarm_indication_state(alarm_indication_state)
   );

   // =====================================================
   // event sources
   always_comb
   begin
      events = '0;
      events[`E3A_BIT_LOSS_IRQ] = (frame_loss_state != loss_prev_r);
      events[`E3A_BIT_ALARM_IRQ] = (alarm_indication_state != alarm_prev_r);
      events[`E3A_BIT_ALIGN_IRQ] = frame_alignment_change;
   end

   // =====================================================
   // register file next values
   always_comb
   begin
      timing_sel_nxt = timing_sel_r;
      irq_en_nxt = irq_en_r;
      rdata_nxt = rdata_r;
      clear_on_read = clk_en & reg_rd & hit(reg_addr, `E3A_ADDR_IRQ_STAT1);
      if (reg_wr && hit(reg_addr, `E3A_ADDR_IRQ_EN1))
         irq_en_nxt = reg_wdata[`E3A_IRQ_EN_WIDTH-1:0];
      if (reg_wr && hit(reg_addr, `E3A_ADDR_CFG_STAT2))
         timing_sel_nxt = reg_wdata[`E3A_BIT_TIMING_SEL];
      if (reg_rd)
      begin
         rdata_nxt = 8'h00;
         if (hit(reg_addr, `E3A_ADDR_CFG_STAT2))
         begin
            rdata_nxt[`E3A_BIT_TIMING_SEL] = timing_sel_r;
            rdata_nxt[`E3A_BIT_LOSS_STATE] = frame_loss_state;
            rdata_nxt[`E3A_BIT_OOF_STATE] = out_of_frame_state;
            rdata_nxt[`E3A_BIT_ALARM_STATE] = alarm_indication_state;
         end
         else if (hit(reg_addr, `E3A_ADDR_IRQ_EN1))
            rdata_nxt = {3'h0, irq_en_r};
         else if (hit(reg_addr, `E3A_ADDR_IRQ_STAT1))
            rdata_nxt = {3'h0, irq_stat_r};
      end
      // set wins over the read clear
      irq_stat_nxt = (clear_on_read ? '0 : irq_stat_r) | (events & irq_en_r);
   end

   // =====================================================
   // registers
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         timing_sel_r <= `E3A_RST_TIMING_SEL;
         irq_en_r <= `E3A_RST_IRQ_EN1;
         irq_stat_r <= `E3A_RST_IRQ_STAT1;
         rdata_r <= 8'h00;
         loss_prev_r <= 1'b0;
         alarm_prev_r <= 1'b0;
      end
      else if (clk_en)
      begin
         timing_sel_r <= timing_sel_nxt;
         irq_en_r <= irq_en_nxt;
         irq_stat_r <= irq_stat_nxt;
         rdata_r <= rdata_nxt;
         loss_prev_r <= frame_loss_state;
         alarm_prev_r <= alarm_indication_state;
      end
   end

   assign reg_rdata = rdata_r;
   assign irq_n = ~|(irq_stat_r & irq_en_r);

endmodule

`default_nettype wire

// ---- e3_rx_alarm_props.sv ----
// port-level checks for the receive alarm interrupt block
// assumes it is bound into e3_rx_alarm_interrupts
`default_nettype none
module e3_rx_alarm_props #(
   parameter int ALIGN_W = 11,
   parameter int LOSS_SHORT_CYC = 20,
   parameter int LOSS_LONG_CYC = 60
)(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic rx_frame_end,
   input wire logic rx_fas_error,
   input wire logic rx_sync_found,
   input wire logic [ALIGN_W-1:0] rx_sync_align,
   input wire logic [ALIGN_W-1:0] payload_align,
   input wire logic out_of_frame_state,
   input wire logic frame_loss_state,
   input wire logic alarm_indication_state,
   input wire logic irq_n
);
   // ====================
   // cycles spent out of frame
   logic [19:0] oof_cnt_r;
   logic [19:0] oof_cnt_nxt;
   always_comb
   begin
      oof_cnt_nxt = out_of_frame_state ? oof_cnt_r + 20'h1 : 20'h0;
   end
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         oof_cnt_r <= 20'h0;
      else
         oof_cnt_r <= oof_cnt_nxt;
   end
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);
   // ====================
   // checks
   a_oof_after_errors: assert property ($rose(out_of_frame_state) |->
      $past(rx_frame_end && rx_fas_error) || $past(rx_frame_end && rx_fas_error, 2)) else $error("oof without error");
   a_loss_in_oof: assert property (frame_loss_state |-> out_of_frame_state)
      else $error("loss outside oof");
   a_loss_window: assert property ($rose(frame_loss_state) |->
      oof_cnt_r >= LOSS_SHORT_CYC - 1 && oof_cnt_r <= LOSS_LONG_CYC + 2) else $error("loss timing");
   a_align_held: assert property ($changed(payload_align) |->
      $past(rx_sync_found && out_of_frame_state)) else $error("alignment moved");
   a_resync_loads: assert property (rx_sync_found && out_of_frame_state && clk_en |=>
      !out_of_frame_state && !frame_loss_state && payload_align == $past(rx_sync_align)) else $error("resync");
   a_alarm_at_frame: assert property ($changed(alarm_indication_state) |->
      $past(rx_frame_end) || $past(rx_frame_end, 2)) else $error("alarm off frame end");
   a_rdata_on_read: assert property ($changed(reg_rdata) |-> $past(reg_rd && clk_en))
      else $error("rdata moved");
   a_live_state: assert property (reg_rd && clk_en && reg_addr == 8'h11 |=>
      reg_rdata[6:3] == {$past(frame_loss_state), $past(out_of_frame_state), 2'h0} |
      {3'h0, $past(alarm_indication_state)}) else $error("live state");
   a_irq_release: assert property ($rose(irq_n) |-> $past(reg_rd || reg_wr))
      else $error("irq released alone");
   c_irq: cover property ($fell(irq_n));
   c_loss: cover property ($rose(frame_loss_state));
   c_align: cover property ($changed(payload_align));
endmodule
bind e3_rx_alarm_interrupts e3_rx_alarm_props #(.ALIGN_W(ALIGN_W), .LOSS_SHORT_CYC(LOSS_SHORT_CYC),
   .LOSS_LONG_CYC(LOSS_LONG_CYC)) e3_rx_alarm_props_i (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_frame_end(rx_frame_end),
   .rx_fas_error(rx_fas_error), .rx_sync_found(rx_sync_found), .rx_sync_align(rx_sync_align),
   .payload_align(payload_align), .out_of_frame_state(out_of_frame_state), .frame_loss_state(frame_loss_state),
   .alarm_indication_state(alarm_indication_state), .irq_n(irq_n));
`default_nettype wire

// ---- e3_framer_src.sv ----
// framer-side source: received bits, frame ends, alignment errors, resync
// assumes the block samples its inputs on rising sys_clk
`default_nettype none
module e3_framer_src #(
   parameter int ALIGN_W = 11,
   parameter int FLEN = 16
)(
   input wire logic sys_clk,
   output logic rx_bit_valid,
   output logic rx_bit,
   output logic rx_frame_end,
   output logic rx_fas_error,
   output logic rx_sync_found,
   output logic [ALIGN_W-1:0] rx_sync_align
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      rx_bit_valid = 1'b0;
      rx_bit = 1'b0;
      rx_frame_end = 1'b0;
      rx_fas_error = 1'b0;
      rx_sync_found = 1'b0;
      rx_sync_align = '0;
   end
   // ====================
   // n frames, first z bits of each zero
   task automatic frames(input int n, input int z, input logic err);
      repeat (n)
      begin
         for (int i = 0; i < FLEN; i++)
         begin
            @(posedge sys_clk);
            rx_bit_valid <= 1'b1;
            rx_bit <= (i >= z);
            rx_frame_end <= (i == FLEN - 1);
            rx_fas_error <= (i == FLEN - 1) ? err : !err;
         end
      end
      @(posedge sys_clk);
      rx_bit_valid <= 1'b0;
      rx_frame_end <= 1'b0;
      rx_bit <= !rx_bit;
      rx_fas_error <= !rx_fas_error;
   endtask
   task automatic resync(input logic [ALIGN_W-1:0] a);
      @(posedge sys_clk);
      rx_sync_found <= 1'b1;
      rx_sync_align <= a;
      @(posedge sys_clk);
      rx_sync_found <= 1'b0;
      rx_sync_align <= ~a;
   endtask
endmodule
`default_nettype wire

// ---- e3_rx_alarm_interrupts_tb.sv ----
// self-checking bench for the receive alarm interrupt block
// assumes the framer source model and the bound checker
`default_nettype none
module e3_rx_alarm_interrupts_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SHORT = 20;
   localparam int LONG = 60;
   logic sys_clk, arst_n, clk_en, reg_wr, reg_rd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic rx_bit_valid, rx_bit, rx_frame_end, rx_fas_error, rx_sync_found;
   logic [10:0] rx_sync_align, payload_align;
   logic out_of_frame_state, frame_loss_state, alarm_indication_state, irq_n;
   int failures = 0;
   int n_tests = 0;
   e3_rx_alarm_interrupts #(.ALIGN_W(11), .LOSS_SHORT_CYC(SHORT), .LOSS_LONG_CYC(LONG)) e3_rx_alarm_interrupts_i (
      .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_bit_valid(rx_bit_valid),
      .rx_bit(rx_bit), .rx_frame_end(rx_frame_end), .rx_fas_error(rx_fas_error), .rx_sync_found(rx_sync_found),
      .rx_sync_align(rx_sync_align), .payload_align(payload_align), .out_of_frame_state(out_of_frame_state),
      .frame_loss_state(frame_loss_state), .alarm_indication_state(alarm_indication_state), .irq_n(irq_n));
   e3_framer_src #(.ALIGN_W(11), .FLEN(16)) e3_framer_src_i (.sys_clk(sys_clk), .rx_bit_valid(rx_bit_valid),
      .rx_bit(rx_bit), .rx_frame_end(rx_frame_end), .rx_fas_error(rx_fas_error),
      .rx_sync_found(rx_sync_found), .rx_sync_align(rx_sync_align));
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // ====================
   // access and compare tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic fr(input int n, input int z, input logic err);
      e3_framer_src_i.frames(n, z, err);
      idle(3);
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      #100000;
      failures++;
      results();
   end
   // ====================
   // test sequence
   initial
   begin
      arst_n = 1'b0;
      clk_en = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      repeat (5) @(posedge sys_clk);
      arst_n <= 1'b1;
      idle(1);
      chk(irq_n, 16'h1);
      rc(8'h12, 8'h00);
      rc(8'h14, 8'h00);
      rc(8'h11, 8'h00);
      rc(8'h3C, 8'h00);
      wr(8'h12, 8'hFF);
      rc(8'h12, 8'h1F);
      wr(8'h14, 8'hFF);
      rc(8'h14, 8'h00);
      fr(1, 7, 1'b0);
      fr(1, 8, 1'b0);
      fr(1, 7, 1'b0);
      rc(8'h11, 8'h00);
      fr(1, 7, 1'b0);
      chk(irq_n, 16'h0);
      rc(8'h11, 8'h08);
      rc(8'h14, 8'h01);
      chk(irq_n, 16'h1);
      rc(8'h14, 8'h00);
      fr(1, 8, 1'b0);
      fr(1, 7, 1'b0);
      fr(1, 8, 1'b0);
      rc(8'h11, 8'h08);
      fr(1, 8, 1'b0);
      rc(8'h11, 8'h00);
      rc(8'h14, 8'h01);
      fr(3, 8, 1'b1);
      fr(1, 8, 1'b0);
      rc(8'h11, 8'h00);
      fr(4, 8, 1'b1);
      rc(8'h11, 8'h20);
      idle(SHORT + 4);
      rc(8'h11, 8'h60);
      chk(payload_align, 16'h0);
      rc(8'h14, 8'h04);
      e3_framer_src_i.resync(11'h155);
      idle(3);
      chk(payload_align, 16'h155);
      rc(8'h11, 8'h00);
      rc(8'h14, 8'h14);
      wr(8'h12, 8'h00);
      fr(4, 8, 1'b1);
      idle(SHORT + 8);
      chk(irq_n, 16'h1);
      e3_framer_src_i.resync(11'h2AA);
      idle(3);
      rc(8'h14, 8'h00);
      wr(8'h12, 8'h10);
      fr(4, 8, 1'b1);
      e3_framer_src_i.resync(11'h2AA);
      idle(3);
      rc(8'h14, 8'h00);
      chk(payload_align, 16'h2AA);
      wr(8'h11, 8'h80);
      rc(8'h11, 8'h80);
      wr(8'h12, 8'h04);
      fr(4, 8, 1'b1);
      idle(SHORT + 8);
      rc(8'h11, 8'hA0);
      idle(LONG);
      rc(8'h11, 8'hE0);
      rc(8'h14, 8'h04);
      // a write taken while the clock enable is low must not land
      @(posedge sys_clk);
      clk_en <= 1'b0;
      wr(8'h12, 8'h00);
      @(posedge sys_clk);
      clk_en <= 1'b1;
      rc(8'h12, 8'h04);
      results();
   end
endmodule
`default_nettype wire
